/* rtl/aats_regs.svh */
// constants for the auto-ack transaction sequencer
`ifndef AATS_REGS_SVH
`define AATS_REGS_SVH
`define AATS_CLK_NS          10
`define AATS_SETTLE_US       130
`define AATS_SETTLE_CYC      ((`AATS_SETTLE_US * 1000 + `AATS_CLK_NS - 1) / `AATS_CLK_NS)
`define AATS_ACK_TMO_US      250
`define AATS_ACK_TMO_CYC     (`AATS_ACK_TMO_US * 1000 / `AATS_CLK_NS)
`define AATS_ACK_TMO_SLOW_US 500
`define AATS_ACK_TMO_SLOW_CYC (`AATS_ACK_TMO_SLOW_US * 1000 / `AATS_CLK_NS)
`define AATS_ARD_STEP_US     250
`define AATS_ARD_STEP_CYC    (`AATS_ARD_STEP_US * 1000 / `AATS_CLK_NS)
`define AATS_BIT_NS_1M       1000
`define AATS_BIT_NS_2M       500
`define AATS_BIT_NS_250K     4000
`define AATS_CYC_1M          (`AATS_BIT_NS_1M / `AATS_CLK_NS)
`define AATS_CYC_2M          (`AATS_BIT_NS_2M / `AATS_CLK_NS)
`define AATS_CYC_250K        (`AATS_BIT_NS_250K / `AATS_CLK_NS)
`define AATS_PREAMBLE_BYTES  1
`define AATS_CTRL_BITS       9
`define AATS_TMR_W           20
`define AATS_TAG_W           8
`define AATS_WORD_W          9
`define AATS_BUF_DEPTH       2
`endif

/* rtl/aats_pkg.sv */
// types of the auto-ack transaction sequencer
`default_nettype none
package aats_pkg;
  typedef enum logic [1:0] {
    AATS_RATE_1M   = 2'b00,
    AATS_RATE_2M   = 2'b01,
    AATS_RATE_250K = 2'b10
  } aats_rate_t;

  typedef enum logic [3:0] {
    AATS_IDLE       = 4'b0000,
    AATS_TX_SETTLE  = 4'b0001,
    AATS_TX_AIR     = 4'b0010,
    AATS_ACK_WAIT   = 4'b0011,
    AATS_ACK_RECV   = 4'b0100,
    AATS_RETRY_WAIT = 4'b0101,
    AATS_RX_LISTEN  = 4'b0110,
    AATS_RX_SETTLE  = 4'b0111,
    AATS_RX_ACK_AIR = 4'b1000
  } aats_state_t;
endpackage
`default_nettype wire

/* rtl/aats_stream_if.sv */
// valid/ready word stream between sequencer parts
`timescale 1ns/1ps
`default_nettype none
`include "aats_regs.svh"
interface aats_stream_if;
  logic                    valid;
  logic                    ready;
  logic [`AATS_WORD_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* rtl/aats_buf2.sv */
// two-entry transmit queue buffer
`timescale 1ns/1ps
`default_nettype none
`include "aats_regs.svh"
module aats_buf2 (
  input  wire logic   clk,
  input  wire logic   reset,
  aats_stream_if.snk  push,
  aats_stream_if.src  pop
);
  import aats_pkg::*;

  logic [`AATS_WORD_W-1:0] mem_r [`AATS_BUF_DEPTH];
  logic                    wr_ptr_r;
  logic                    rd_ptr_r;
  logic [1:0]              cnt_r;
  logic                    do_wr;
  logic                    do_rd;

  assign push.ready = (cnt_r != 2'd2);
  assign pop.valid  = (cnt_r != 2'd0);
  assign pop.data   = mem_r[rd_ptr_r];
  assign do_wr      = push.valid && push.ready;
  assign do_rd      = pop.valid && pop.ready;

  for (genvar i = 0; i < `AATS_BUF_DEPTH; i++) begin : g_entry
    always_ff @(posedge clk) begin
      if (reset) begin
        mem_r[i] <= '0;
      end else if (do_wr && (wr_ptr_r == 1'(i))) begin
        mem_r[i] <= push.data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r    <= 2'd0;
    end else begin
      if (do_wr) wr_ptr_r <= ~wr_ptr_r;
      if (do_rd) rd_ptr_r <= ~rd_ptr_r;
      if (do_wr && !do_rd) cnt_r <= cnt_r + 2'd1;
      else if (do_rd && !do_wr) cnt_r <= cnt_r - 2'd1;
    end
  end
endmodule
`default_nettype wire

/* rtl/aats_sequencer.sv */
// auto-ack transaction sequencer, transmitter and receiver roles
// Contract
// R1: static mode sends once without ack; autonomous mode sequences everything.
// R2: each autonomous sequence ends with an event on the interrupt pin.
// R3: skip-ack packet raises the interrupt right after sending.
// R4: host holds activate high while the receiver should listen.
// R5: host pulses activate high at least 10 us to start a send.
// R6: transmitter settles 130 us before the packet goes on air.
// R7: after sending with ack expected, transmitter turns to receive.
// R8: receiver flags a packet then turns round to send the ack.
// R9: ack received raises interrupt and drops the packet from the queue.
// R10: receiver sets data-ready flag once a packet is complete.
// R11: data-sent flag is set only once the ack has arrived; the code also sets it at the end of a skip-ack send.
// R12: missing ack within the wait window causes a resend of the packet.
// R13: ack wait times out after 250 us, or 500 us at the slow rate.
// R14: end of send to start of resend is the wait in 250 us steps.
// R15: retry limit reached raises retry-limit flag and returns to idle.
// R16: interrupt pin is active low, fed by three maskable sources.
// R17: airtime is eight bits per byte plus nine control bits over rate.
`timescale 1ns/1ps
`default_nettype none
`include "aats_regs.svh"
module aats_sequencer #(
  parameter int unsigned SETTLE_CYC       = `AATS_SETTLE_CYC,
  parameter int unsigned ACK_TMO_CYC      = `AATS_ACK_TMO_CYC,
  parameter int unsigned ACK_TMO_SLOW_CYC = `AATS_ACK_TMO_SLOW_CYC,
  parameter int unsigned ARD_STEP_CYC     = `AATS_ARD_STEP_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   activate,
  input  wire logic                   role_is_transmitter,
  input  wire logic                   auto_ack_enable,
  input  wire aats_pkg::aats_rate_t   air_rate,
  input  wire logic [2:0]             addr_bytes,
  input  wire logic [5:0]             payload_bytes,
  input  wire logic [1:0]             crc_bytes,
  input  wire logic [3:0]             retransmit_wait,
  input  wire logic [3:0]             retry_limit_count,
  input  wire logic                   mask_rx_ready,
  input  wire logic                   mask_tx_sent,
  input  wire logic                   mask_retry_limit,
  input  wire logic                   clear_rx_ready,
  input  wire logic                   clear_tx_sent,
  input  wire logic                   clear_retry_limit,
  input  wire logic                   tx_push_valid,
  output logic                        tx_push_ready,
  input  wire logic [`AATS_TAG_W-1:0] tx_push_tag,
  input  wire logic                   tx_push_no_ack,
  input  wire logic                   phy_addr_match,
  input  wire logic                   phy_pkt_done,
  input  wire logic                   phy_pkt_crc_ok,
  input  wire logic                   phy_pkt_no_ack,
  input  wire logic [`AATS_TAG_W-1:0] phy_rx_tag,
  output logic                        phy_tx_on,
  output logic                        phy_rx_on,
  output logic [`AATS_TAG_W-1:0]      air_tag_r,
  output logic [`AATS_TAG_W-1:0]      rx_tag_r,
  output logic [3:0]                  retry_cnt_r,
  output logic                        rx_data_ready_flag,
  output logic                        tx_data_sent_flag,
  output logic                        retry_limit_flag,
  output logic                        irq_n
);
  import aats_pkg::*;

  localparam int TW = `AATS_TMR_W;

  aats_state_t    state_r;
  logic [TW-1:0]  tmr_r;
  logic [TW-1:0]  ard_r;
  logic           act_m_r;
  logic           act_s_r;
  logic           blocked_r;
  logic           rx_flag_r;
  logic           tx_flag_r;
  logic           rt_flag_r;
  logic           irq_n_r;
  logic           set_rx;
  logic           set_tx;
  logic           set_rt;
  logic           pop;
  logic           head_no_ack;
  logic           skip_ack;
  logic           lost;
  logic           tmr_zero;
  logic [TW-1:0]  ack_tmo;
  logic [TW-1:0]  ard_cyc;

  aats_stream_if u_push ();
  aats_stream_if u_head ();

  assign u_push.valid = tx_push_valid;
  assign u_push.data  = {tx_push_no_ack, tx_push_tag};
  assign tx_push_ready = u_push.ready;
  assign u_head.ready = pop;
  assign head_no_ack  = u_head.data[`AATS_WORD_W-1];

  aats_buf2 u_buf (
    .clk   (clk),
    .reset (reset),
    .push  (u_push),
    .pop   (u_head)
  );

  // airtime in clock cycles for a packet of the given payload
  function automatic logic [TW-1:0] air_cyc(input logic [5:0] pay);
    logic [6:0]    bytes;
    logic [9:0]    bits;
    logic [TW-1:0] per;
    bytes = 7'(`AATS_PREAMBLE_BYTES) + {4'h0, addr_bytes}
          + {1'b0, pay} + {5'h00, crc_bytes};
    bits = {bytes, 3'b000} + 10'(`AATS_CTRL_BITS); // R17
    unique case (air_rate)
      AATS_RATE_2M:   per = TW'(`AATS_CYC_2M);
      AATS_RATE_250K: per = TW'(`AATS_CYC_250K);
      default:        per = TW'(`AATS_CYC_1M);
    endcase
    air_cyc = TW'({10'h000, bits} * per); // R17
  endfunction

  assign tmr_zero = (tmr_r == '0);
  assign ack_tmo  = (air_rate == AATS_RATE_250K) ? TW'(ACK_TMO_SLOW_CYC)
                                                 : TW'(ACK_TMO_CYC); // R13
  assign ard_cyc  = TW'(({16'h0000, retransmit_wait} + 20'h00001)
                  * TW'(ARD_STEP_CYC)); // R14
  // static mode behaves as a send without acknowledgement
  assign skip_ack = head_no_ack || !auto_ack_enable; // R1 R3
  assign lost = ((state_r == AATS_ACK_WAIT) && !phy_addr_match && tmr_zero)
             || ((state_r == AATS_ACK_RECV) && phy_pkt_done
                 && !phy_pkt_crc_ok); // R12 R13

  // activate arrives from a pin
  always_ff @(posedge clk) begin
    if (reset) begin
      act_m_r <= 1'b0;
      act_s_r <= 1'b0;
    end else begin
      act_m_r <= activate;
      act_s_r <= act_m_r;
    end
  end

  always_comb begin
    set_rx = 1'b0;
    set_tx = 1'b0;
    set_rt = 1'b0;
    pop    = 1'b0;
    unique case (state_r)
      AATS_TX_AIR: begin
        if (tmr_zero && skip_ack) begin
          set_tx = 1'b1; // R3
          pop    = 1'b1;
        end
      end
      AATS_ACK_RECV: begin
        if (phy_pkt_done && phy_pkt_crc_ok) begin
          set_tx = 1'b1; // R9 R11
          pop    = 1'b1; // R9
        end
      end
      AATS_RX_LISTEN: begin
        if (act_s_r && phy_pkt_done && phy_pkt_crc_ok) set_rx = 1'b1; // R10
      end
      default: begin
      end
    endcase
    if (lost && (retry_cnt_r == retry_limit_count)) set_rt = 1'b1; // R15
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r     <= AATS_IDLE;
      tmr_r       <= '0;
      retry_cnt_r <= 4'h0;
      air_tag_r   <= '0;
      rx_tag_r    <= '0;
    end else begin
      if (!tmr_zero) tmr_r <= tmr_r - TW'(1);
      unique case (state_r)
        AATS_IDLE: begin
          if (role_is_transmitter) begin
            // a send starts on activate with a queued packet
            if (act_s_r && !blocked_r && u_head.valid) begin // R5
              state_r     <= AATS_TX_SETTLE;
              tmr_r       <= TW'(SETTLE_CYC - 1); // R6
              retry_cnt_r <= 4'h0;
            end
          end else if (act_s_r) begin
            state_r <= AATS_RX_LISTEN; // R4
          end
        end
        AATS_TX_SETTLE: begin
          if (tmr_zero) begin
            state_r   <= AATS_TX_AIR; // R6
            tmr_r     <= air_cyc(payload_bytes) - TW'(1);
            air_tag_r <= u_head.data[`AATS_TAG_W-1:0];
          end
        end
        AATS_TX_AIR: begin
          if (tmr_zero) begin
            if (skip_ack) begin
              state_r <= AATS_IDLE; // R3
            end else begin
              state_r <= AATS_ACK_WAIT; // R7
              tmr_r   <= ack_tmo - TW'(1); // R13
            end
          end
        end
        AATS_ACK_WAIT: begin
          if (phy_addr_match) state_r <= AATS_ACK_RECV;
          else if (lost && set_rt) state_r <= AATS_IDLE; // R15
          else if (lost) begin
            state_r     <= AATS_RETRY_WAIT; // R12
            retry_cnt_r <= retry_cnt_r + 4'h1;
          end
        end
        AATS_ACK_RECV: begin
          if (phy_pkt_done && phy_pkt_crc_ok) state_r <= AATS_IDLE; // R9
          else if (lost && set_rt) state_r <= AATS_IDLE; // R15
          else if (lost) begin
            state_r     <= AATS_RETRY_WAIT; // R12
            retry_cnt_r <= retry_cnt_r + 4'h1;
          end
        end
        AATS_RETRY_WAIT: begin
          if (ard_r == '0) begin
            state_r <= AATS_TX_AIR; // R14
            tmr_r   <= air_cyc(payload_bytes) - TW'(1);
          end
        end
        AATS_RX_LISTEN: begin
          if (!act_s_r) state_r <= AATS_IDLE; // R4
          else if (set_rx) begin
            rx_tag_r <= phy_rx_tag;
            if (auto_ack_enable && !phy_pkt_no_ack) begin
              state_r <= AATS_RX_SETTLE; // R8
              tmr_r   <= TW'(SETTLE_CYC - 1);
            end
          end
        end
        AATS_RX_SETTLE: begin
          if (tmr_zero) begin
            state_r <= AATS_RX_ACK_AIR; // R8
            tmr_r   <= air_cyc(6'h00) - TW'(1);
          end
        end
        AATS_RX_ACK_AIR: begin
          if (tmr_zero) state_r <= AATS_RX_LISTEN;
        end
        default: state_r <= AATS_IDLE;
      endcase
    end
  end

  // retransmit wait runs from the end of each send
  always_ff @(posedge clk) begin
    if (reset) begin
      ard_r <= '0;
    end else if ((state_r == AATS_TX_AIR) && tmr_zero) begin
      ard_r <= ard_cyc - TW'(1); // R14
    end else if (ard_r != '0) begin
      ard_r <= ard_r - TW'(1);
    end
  end

  // after the retry limit a fresh activate edge is needed
  always_ff @(posedge clk) begin
    if (reset) blocked_r <= 1'b0;
    else if (set_rt) blocked_r <= 1'b1;
    else if (!act_s_r) blocked_r <= 1'b0;
  end

  // sticky flags; a set in the clear cycle wins
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_flag_r <= 1'b0;
      tx_flag_r <= 1'b0;
      rt_flag_r <= 1'b0;
    end else begin
      rx_flag_r <= set_rx || (rx_flag_r && !clear_rx_ready); // R10
      tx_flag_r <= set_tx || (tx_flag_r && !clear_tx_sent); // R11
      rt_flag_r <= set_rt || (rt_flag_r && !clear_retry_limit); // R15
    end
  end

  always_ff @(posedge clk) begin
    if (reset) irq_n_r <= 1'b1;
    else irq_n_r <= !((rx_flag_r && !mask_rx_ready)
                   || (tx_flag_r && !mask_tx_sent)
                   || (rt_flag_r && !mask_retry_limit)); // R2 R16
  end

  assign rx_data_ready_flag = rx_flag_r;
  assign tx_data_sent_flag  = tx_flag_r;
  assign retry_limit_flag   = rt_flag_r;
  assign irq_n              = irq_n_r;
  assign phy_tx_on = (state_r == AATS_TX_AIR) || (state_r == AATS_RX_ACK_AIR);
  assign phy_rx_on = (state_r == AATS_ACK_WAIT) || (state_r == AATS_ACK_RECV)
                  || (state_r == AATS_RX_LISTEN);

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_irq;
    (tx_flag_r && !mask_tx_sent) |=> !irq_n;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not low"); // R16 R2

  property p_settle;
    (state_r == AATS_IDLE) ##1 (state_r == AATS_TX_SETTLE)
      |-> tmr_r == TW'(SETTLE_CYC - 1);
  endproperty
  a_settle: assert property (p_settle) else $error("bad settle"); // R6

  property p_noack;
    (state_r == AATS_TX_AIR && tmr_zero && skip_ack)
      |=> state_r == AATS_IDLE && tx_flag_r;
  endproperty
  a_noack: assert property (p_noack) else $error("no-ack end"); // R3

  property p_turn;
    (state_r == AATS_TX_AIR && tmr_zero && !skip_ack)
      |=> state_r == AATS_ACK_WAIT && tmr_r == ack_tmo - TW'(1);
  endproperty
  a_turn: assert property (p_turn) else $error("no turnaround"); // R7 R13

  property p_ack;
    (state_r == AATS_ACK_RECV && phy_pkt_done && phy_pkt_crc_ok)
      |-> pop ##1 (tx_flag_r && state_r == AATS_IDLE);
  endproperty
  a_ack: assert property (p_ack) else $error("ack not taken"); // R9

  property p_sent_cause;
    $rose(tx_flag_r) |-> $past(state_r) inside {AATS_TX_AIR, AATS_ACK_RECV};
  endproperty
  a_sent_cause: assert property (p_sent_cause) else $error("stray sent"); // R11

  property p_rx;
    (state_r == AATS_RX_LISTEN && set_rx && auto_ack_enable
     && !phy_pkt_no_ack) |=> rx_flag_r && state_r == AATS_RX_SETTLE;
  endproperty
  a_rx: assert property (p_rx) else $error("rx not flagged"); // R8 R10

  property p_retry;
    (lost && retry_cnt_r != retry_limit_count)
      |=> state_r == AATS_RETRY_WAIT && retry_cnt_r == $past(retry_cnt_r) + 4'h1;
  endproperty
  a_retry: assert property (p_retry) else $error("no retry"); // R12

  property p_maxrt;
    (lost && retry_cnt_r == retry_limit_count)
      |=> rt_flag_r && state_r == AATS_IDLE ##1 !irq_n || mask_retry_limit;
  endproperty
  a_maxrt: assert property (p_maxrt) else $error("limit missed"); // R15

  property p_ard;
    (state_r == AATS_RETRY_WAIT && ard_r == '0) |=> state_r == AATS_TX_AIR;
  endproperty
  a_ard: assert property (p_ard) else $error("resend late"); // R14

  c_ack_ok: cover property (state_r == AATS_ACK_RECV ##1 tx_flag_r);
  c_limit:  cover property (set_rt);
  c_rx_ack: cover property (state_r == AATS_RX_ACK_AIR ##1
                            state_r == AATS_RX_LISTEN);
endmodule
`default_nettype wire

/* verification/aats_peer_model.sv */
// peer radio model: answers acks and injects received packets
`timescale 1ns/1ps
`default_nettype none
module aats_peer_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       phy_rx_on,
  input  wire logic [7:0] air_tag_r,
  input  wire logic       ack_en,
  input  wire logic [7:0] ack_delay,
  input  wire logic       inject,
  input  wire logic [1:0] inj_bits,
  input  wire logic [7:0] inj_tag,
  output logic            phy_addr_match,
  output logic            phy_pkt_done,
  output logic            phy_pkt_crc_ok,
  output logic            phy_pkt_no_ack,
  output logic [7:0]      phy_rx_tag
);
  logic       rx_d_r;
  logic       busy_r;
  logic [7:0] cnt_r;
  logic [7:0] noise_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      {rx_d_r, busy_r, cnt_r, noise_r} <= '0;
      {phy_addr_match, phy_pkt_done, phy_pkt_crc_ok} <= 3'h0;
      {phy_pkt_no_ack, phy_rx_tag} <= 9'h000;
    end else begin
      rx_d_r         <= phy_rx_on;
      noise_r        <= noise_r + 8'h5b;
      phy_addr_match <= 1'b0;
      phy_pkt_done   <= 1'b0;
      // qualifiers carry changing junk outside a packet end
      {phy_pkt_crc_ok, phy_pkt_no_ack, phy_rx_tag} <= {noise_r[1:0], noise_r};
      if (inject) begin
        phy_pkt_done <= 1'b1;
        {phy_pkt_crc_ok, phy_pkt_no_ack, phy_rx_tag} <= {inj_bits, inj_tag};
      end else if (ack_en && phy_rx_on && !rx_d_r) begin
        busy_r <= 1'b1;
        cnt_r  <= 8'h00;
      end else if (busy_r) begin
        cnt_r          <= cnt_r + 8'h01;
        phy_addr_match <= (cnt_r == ack_delay);
        if (cnt_r == ack_delay + 8'h14) begin
          busy_r       <= 1'b0;
          phy_pkt_done <= 1'b1;
          {phy_pkt_crc_ok, phy_pkt_no_ack, phy_rx_tag} <= {2'b10, air_tag_r};
        end
      end
    end
  end
endmodule
`default_nettype wire

/* verification/aats_sequencer_test.sv */
// self-checking bench for the auto-ack transaction sequencer
`timescale 1ns/1ps
`default_nettype none
module aats_sequencer_test;
  import aats_pkg::*;
  localparam int SETTLE   = 20;
  localparam int TMO      = 40;
  localparam int TMO_SLOW = 80;
  localparam int RETRANSMIT_WAIT      = 30;
  localparam int AIR_FAST = (8 * (1 + 3 + 0 + 1) + 9) * 50;
  localparam int AIR_SLOW = (8 * (1 + 3 + 0 + 2) + 9) * 400;
  localparam int AIR_MID  = (8 * (1 + 5 + 4 + 1) + 9) * 100;
  logic       clk = 1'b0, reset = 1'b1, activate = 1'b0, role_tx = 1'b1;
  logic       auto_ack = 1'b1, push_v = 1'b0, push_na = 1'b0;
  logic       ack_en = 1'b1, inject = 1'b0;
  aats_rate_t rate = AATS_RATE_2M;
  logic [1:0] crc_n = 2'h1, inj_bits = 2'h0;
  logic [3:0] ard_val = 4'h1, limit = 4'h1;
  logic [5:0] pay_n = 6'h00;
  logic [2:0] addr_n = 3'h3;
  logic [2:0] mask = 3'h0, clr = 3'h0;
  logic [7:0] push_tag = 8'h00, ack_delay = 8'h01, inj_tag = 8'h00;
  logic       push_ready, match, done, crc_ok, pkt_na, tx_on, rx_on;
  logic       f_rx, f_tx, f_rl, irq_n;
  logic [7:0] rx_tag, air_tag, rxt;
  logic [3:0] retry_cnt;
  int         mismatches = 0, n_checks = 0, cyc = 0;

  aats_sequencer #(.SETTLE_CYC(SETTLE), .ACK_TMO_CYC(TMO),
    .ACK_TMO_SLOW_CYC(TMO_SLOW), .ARD_STEP_CYC(RETRANSMIT_WAIT)) dut_u (
    .clk(clk), .reset(reset), .activate(activate),
    .role_is_transmitter(role_tx), .auto_ack_enable(auto_ack),
    .air_rate(rate), .addr_bytes(addr_n), .payload_bytes(pay_n),
    .crc_bytes(crc_n), .retransmit_wait(ard_val), .retry_limit_count(limit),
    .mask_rx_ready(mask[0]), .mask_tx_sent(mask[1]),
    .mask_retry_limit(mask[2]), .clear_rx_ready(clr[0]),
    .clear_tx_sent(clr[1]), .clear_retry_limit(clr[2]),
    .tx_push_valid(push_v), .tx_push_ready(push_ready),
    .tx_push_tag(push_tag), .tx_push_no_ack(push_na),
    .phy_addr_match(match), .phy_pkt_done(done), .phy_pkt_crc_ok(crc_ok),
    .phy_pkt_no_ack(pkt_na), .phy_rx_tag(rx_tag), .phy_tx_on(tx_on),
    .phy_rx_on(rx_on), .air_tag_r(air_tag), .rx_tag_r(rxt),
    .retry_cnt_r(retry_cnt), .rx_data_ready_flag(f_rx),
    .tx_data_sent_flag(f_tx), .retry_limit_flag(f_rl), .irq_n(irq_n));

  aats_peer_model peer_u (.clk(clk), .reset(reset), .phy_rx_on(rx_on),
    .air_tag_r(air_tag), .ack_en(ack_en), .ack_delay(ack_delay),
    .inject(inject), .inj_bits(inj_bits), .inj_tag(inj_tag),
    .phy_addr_match(match), .phy_pkt_done(done), .phy_pkt_crc_ok(crc_ok),
    .phy_pkt_no_ack(pkt_na), .phy_rx_tag(rx_tag));

  always #5 clk = ~clk;

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask

  task automatic edges(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return tx_on;
      1: return rx_on;
      2: return f_tx;
      3: return f_rl;
      default: return f_rx;
    endcase
  endfunction

  // counts edges until the chosen output reaches lvl, bounded
  task automatic wait_sig(input int s, input logic lvl, output int n);
    n = 0;
    while (sig(s) !== lvl && n < 30000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  task automatic push(input logic [7:0] tag, input logic na);
    @(posedge clk);
    push_v   <= 1'b1;
    push_tag <= tag;
    push_na  <= na;
    #1;
    while (push_ready !== 1'b1) edges(1);
    @(posedge clk);
    push_v <= 1'b0;
    #1;
  endtask

  task automatic act(input logic v);
    @(posedge clk);
    activate <= v;
    #1;
  endtask

  task automatic clear_flags;
    @(posedge clk);
    clr <= 3'h7;
    @(posedge clk);
    clr <= 3'h0;
    edges(2);
  endtask

  task automatic inj(input logic [7:0] tag, input logic [1:0] bits);
    @(posedge clk);
    inject   <= 1'b1;
    inj_tag  <= tag;
    inj_bits <= bits;
    @(posedge clk);
    inject <= 1'b0;
    #1;
  endtask

  task automatic t_queue_ack;
    int n;
    ack_delay = 8'h19;
    push(8'h5a, 1'b0);
    push(8'ha5, 1'b0);
    check(push_ready, 1'b0);
    act(1'b1);
    wait_sig(0, 1'b1, n);
    check(n inside {[SETTLE + 1:SETTLE + 5]}, 1'b1);
    check(air_tag, 8'h5a);
    wait_sig(0, 1'b0, n);
    check(n, AIR_FAST);
    check(rx_on, 1'b1);
    check(f_tx, 1'b0);
    wait_sig(2, 1'b1, n);
    check(n < 100, 1'b1);
    edges(2);
    check(irq_n, 1'b0);
    check(push_ready, 1'b1);
    ack_delay = 8'h00;
    clear_flags();
    wait_sig(0, 1'b1, n);
    check(air_tag, 8'ha5);
    wait_sig(2, 1'b1, n);
    check(n < AIR_FAST + 100, 1'b1);
    check(retry_cnt, 4'h0);
    act(1'b0);
    clear_flags();
  endtask

  task automatic t_skip;
    int n;
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      auto_ack <= (m == 0);
      rate     <= m ? AATS_RATE_1M : AATS_RATE_2M;
      addr_n   <= m ? 3'h5 : 3'h3;
      pay_n    <= m ? 6'h04 : 6'h00;
      push(8'h30 | m[7:0], m == 0);
      act(1'b1);
      wait_sig(0, 1'b1, n);
      wait_sig(0, 1'b0, n);
      check(n, m ? AIR_MID : AIR_FAST);
      edges(1);
      check(f_tx, 1'b1);
      check(rx_on, 1'b0);
      edges(1);
      check(irq_n, 1'b0);
      @(posedge clk);
      mask <= 3'h2;
      edges(2);
      check(irq_n, 1'b1);
      @(posedge clk);
      mask <= 3'h0;
      act(1'b0);
      clear_flags();
    end
    @(posedge clk);
    auto_ack <= 1'b1;
    rate     <= AATS_RATE_2M;
    addr_n   <= 3'h3;
    pay_n    <= 6'h00;
  endtask

  task automatic t_retry;
    int n, a;
    ack_en = 1'b0;
    push(8'h77, 1'b0);
    act(1'b1);
    wait_sig(0, 1'b1, n);
    wait_sig(0, 1'b0, n);
    wait_sig(1, 1'b1, a);
    wait_sig(1, 1'b0, n);
    check(n inside {[TMO:TMO + 2]}, 1'b1);
    a += n;
    wait_sig(0, 1'b1, n);
    check(a + n inside {[2 * RETRANSMIT_WAIT:2 * RETRANSMIT_WAIT + 1]}, 1'b1);
    check(air_tag, 8'h77);
    check(retry_cnt, 4'h1);
    wait_sig(0, 1'b0, n);
    wait_sig(3, 1'b1, n);
    check(n inside {[TMO:TMO + 4]}, 1'b1);
    check(f_tx, 1'b0);
    edges(2);
    check(irq_n, 1'b0);
    check({tx_on, rx_on}, 2'b00);
    @(posedge clk);
    mask <= 3'h4;
    edges(2);
    check(irq_n, 1'b1);
    @(posedge clk);
    mask <= 3'h0;
    clr  <= 3'h4;
    @(posedge clk);
    clr <= 3'h0;
    edges(2);
    check({f_rl, irq_n}, 2'b01);
    act(1'b0);
    edges(3);
    ack_en = 1'b1;
    act(1'b1);
    wait_sig(0, 1'b1, n);
    check(air_tag, 8'h77);
    wait_sig(2, 1'b1, n);
    check(n < AIR_FAST + 100, 1'b1);
    act(1'b0);
    clear_flags();
  endtask

  task automatic t_slow;
    int n;
    ack_en = 1'b0;
    @(posedge clk);
    rate  <= AATS_RATE_250K;
    crc_n <= 2'h2;
    limit <= 4'h0;
    push(8'h11, 1'b0);
    act(1'b1);
    wait_sig(0, 1'b1, n);
    wait_sig(0, 1'b0, n);
    check(n, AIR_SLOW);
    wait_sig(1, 1'b1, n);
    wait_sig(1, 1'b0, n);
    check(n inside {[TMO_SLOW:TMO_SLOW + 2]}, 1'b1);
    wait_sig(3, 1'b1, n);
    check(n < 5, 1'b1);
    act(1'b0);
    clear_flags();
    @(posedge clk);
    rate  <= AATS_RATE_2M;
    crc_n <= 2'h1;
  endtask

  task automatic t_rx;
    int n;
    @(posedge clk);
    role_tx  <= 1'b0;
    activate <= 1'b1;
    edges(5);
    check(rx_on, 1'b1);
    inj(8'hc3, 2'b10);
    wait_sig(4, 1'b1, n);
    check(n < 5, 1'b1);
    check(rxt, 8'hc3);
    edges(1);
    check(irq_n, 1'b0);
    wait_sig(0, 1'b1, n);
    check(n inside {[SETTLE - 3:SETTLE + 3]}, 1'b1);
    wait_sig(0, 1'b0, n);
    check(n, AIR_FAST);
    edges(1);
    check(rx_on, 1'b1);
    clear_flags();
    for (int m = 0; m < 2; m++) begin
      inj(8'h40 | m[7:0], {m[0], m[0]});
      edges(SETTLE + 5);
      check(f_rx, m[0]);
      check(tx_on, 1'b0);
      check(rxt, m ? 8'h41 : 8'hc3);
    end
    @(posedge clk);
    mask <= 3'h1;
    edges(2);
    check(irq_n, 1'b1);
    @(posedge clk);
    mask <= 3'h0;
    act(1'b0);
    edges(3);
    check(rx_on, 1'b0);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    edges(1);
    t_queue_ack();
    t_skip();
    t_retry();
    t_slow();
    t_rx();
    wrap_up();
  end
endmodule
`default_nettype wire
